// file: common/jtp_pkg.sv
/*
  constants for the test port scan chains: instruction codes, chain
  lengths, fifo size, capture and identification values and tap states.
  assumes one system clock (mclk_i) samples the tester's pins.
*/
package jtp_pkg;

  // ------------------------------------------------------------------
  // instruction codes and widths
  // ------------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_INTEST = 4'h1;
  localparam logic [3:0] INS_SAMPLE = 4'h2;
  localparam logic [3:0] INS_ABORT = 4'h8;
  localparam logic [3:0] INS_DP_ACCESS = 4'ha;
  localparam logic [3:0] INS_AP_ACCESS = 4'hb;
  localparam logic [3:0] INS_IDCODE = 4'he;
  localparam logic [3:0] INS_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ------------------------------------------------------------------
  // chain sizes
  // ------------------------------------------------------------------
  localparam int ACC_W = 35;
  localparam int ID_W = 32;
  localparam int NPAD = 8;
  localparam int BSR_W = 3 * NPAD + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = ACC_W + 2;
  // identification value: arbitrary, lsb must stay one
  localparam logic [31:0] ID_VALUE = 32'h1234_5679;

  // ------------------------------------------------------------------
  // tap states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PAUDR, S_EX2DR,
    S_UPDR, S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PAUIR, S_EX2IR, S_UPIR
  } jtp_state_t;

endpackage : jtp_pkg

// file: logic/jtp_tap.sv
/*
  scan chains behind the test access port, plus the fifo that hands
  updated access words to the debug unit.
  assumes tck, tms, tdi and trst come from the tester, asynchronous to
  mclk_i, with tck much slower than mclk_i.
*/
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// fifo between access chain updates and the debug unit
// ----------------------------------------------------------------------
module jtp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,           // clock
  input wire logic rst_b_i,         // reset, active low
  input wire logic in_valid_i,      // write request
  output logic in_ready_o,          // room left
  input wire logic [W-1:0] in_data_i, // write data
  output logic out_valid_o,         // data held
  input wire logic out_ready_i,     // reader takes
  output logic [W-1:0] out_data_o   // read data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } jtp_fifo_t;
  jtp_fifo_t s_q, s_d;
  logic wr, rd;

  assign in_ready_o = (s_q.cnt != (AW+1)'(D));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o = s_q.mem[s_q.rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;

  // pointers wrap by depth; depth is a power of two
  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (rd) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : jtp_fifo

// ----------------------------------------------------------------------
// top: tap controller, instruction and data chains
// ----------------------------------------------------------------------
module jtp_tap
  import jtp_pkg::*;
#(
  // pad order along the chain, one index per chain slot
  parameter int PAD_ORDER [jtp_pkg::NPAD] = '{0, 1, 2, 3, 4, 5, 6, 7}
) (
  input wire logic mclk_i,                  // system clock, 40 mhz
  input wire logic rst_b_i,                 // power-on reset, low
  input wire logic tck_i,                   // tester clock pin
  input wire logic tms_i,                   // mode select pin
  input wire logic tdi_i,                   // serial data in
  input wire logic trst_b_i,                // test reset pin, low
  output logic tdo_o,                       // serial data out
  output logic tdo_oe_o,                    // tdo driven
  input wire logic [jtp_pkg::NPAD-1:0] pad_in_i,   // pad inputs
  input wire logic [jtp_pkg::NPAD-1:0] core_out_i, // core outputs
  input wire logic [jtp_pkg::NPAD-1:0] core_oe_i,  // core enables
  input wire logic ext_rst_b_i,             // external reset pin level
  output logic [jtp_pkg::NPAD-1:0] pad_out_o,  // to pad drivers
  output logic [jtp_pkg::NPAD-1:0] pad_oe_o,   // to pad enables
  output logic [jtp_pkg::NPAD-1:0] core_in_o,  // to core inputs
  output logic [3:0] instr_o,               // active instruction
  output logic dbg_valid_o,                 // access word ready
  input wire logic dbg_ready_i,             // debug unit takes it
  output logic [1:0] dbg_kind_o,            // 0 abort 2 dp 3 ap
  output logic [jtp_pkg::ACC_W-1:0] dbg_data_o, // updated word
  input wire logic [jtp_pkg::ACC_W-1:0] dbg_rdata_i, // capture value
  output logic abort_o                      // abort pulse
);

  typedef struct packed {
    logic [2:0] rs;
    logic [2:0] tck_s, tms_s, tdi_s, trst_s;
    logic tck_lvl;
    jtp_state_t st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [ACC_W-1:0] dr;   // shared shift chain for id/acc/bypass
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] bsr_hold;
    logic tdo;              // only serial way out of the chains
    logic oe;
    logic abort;
    logic fifo_v;
    logic [FIFO_W-1:0] fifo_w;
  } jtp_top_t;
  jtp_top_t s_q, s_d;

  logic rst_n;
  logic tck_lvl_new, tck_rise, tck_fall, tms_v, tdi_v, trst_v;
  logic in_ready;
  logic [FIFO_W-1:0] fifo_rd;
  jtp_state_t nx;
  logic [BSR_W-1:0] bsr_cap;
  logic [ACC_W-1:0] acc_cap;
  logic is_bsr, is_acc, is_id;

  assign rst_n = s_q.rs[1];

  // ------------------------------------------------------------------
  // pin sampling: a tck or trst change counts when stages two and three agree; tms and tdi take stage three
  // ------------------------------------------------------------------
  assign tck_lvl_new = (s_q.tck_s[1] == s_q.tck_s[2]) ?
                       s_q.tck_s[2] : s_q.tck_lvl;
  assign tck_rise = tck_lvl_new && !s_q.tck_lvl;
  assign tck_fall = !tck_lvl_new && s_q.tck_lvl;
  assign tms_v = s_q.tms_s[2];
  assign tdi_v = s_q.tdi_s[2];
  assign trst_v = (s_q.trst_s[1] == s_q.trst_s[2]) && !s_q.trst_s[2];

  // ------------------------------------------------------------------
  // sixteen-state controller walk on tms
  // ------------------------------------------------------------------
  always_comb begin
    case (s_q.st)
      S_TLR: nx = tms_v ? S_TLR : S_RTI;
      S_RTI: nx = tms_v ? S_SELDR : S_RTI;
      S_SELDR: nx = tms_v ? S_SELIR : S_CAPDR;
      S_CAPDR: nx = tms_v ? S_EX1DR : S_SHDR;
      S_SHDR: nx = tms_v ? S_EX1DR : S_SHDR;
      S_EX1DR: nx = tms_v ? S_UPDR : S_PAUDR;
      S_PAUDR: nx = tms_v ? S_EX2DR : S_PAUDR;
      S_EX2DR: nx = tms_v ? S_UPDR : S_SHDR;
      S_UPDR: nx = tms_v ? S_SELDR : S_RTI;
      S_SELIR: nx = tms_v ? S_TLR : S_CAPIR;
      S_CAPIR: nx = tms_v ? S_EX1IR : S_SHIR;
      S_SHIR: nx = tms_v ? S_EX1IR : S_SHIR;
      S_EX1IR: nx = tms_v ? S_UPIR : S_PAUIR;
      S_PAUIR: nx = tms_v ? S_EX2IR : S_PAUIR;
      S_EX2IR: nx = tms_v ? S_UPIR : S_SHIR;
      S_UPIR: nx = tms_v ? S_SELDR : S_RTI;
      default: nx = S_TLR;
    endcase
  end

  // ------------------------------------------------------------------
  // instruction decode; unlisted codes fall to bypass
  // ------------------------------------------------------------------
  assign is_bsr = (s_q.ir == INS_EXTEST) || (s_q.ir == INS_INTEST) ||
                  (s_q.ir == INS_SAMPLE);
  assign is_acc = (s_q.ir == INS_ABORT) || (s_q.ir == INS_DP_ACCESS) ||
                  (s_q.ir == INS_AP_ACCESS);
  assign is_id = (s_q.ir == INS_IDCODE);

  // capture image: per pad input, output, enable; reset pin last
  always_comb begin
    bsr_cap = '0;
    for (int i = 0; i < NPAD; i++) begin
      bsr_cap[3*i] = pad_in_i[PAD_ORDER[i]];
      bsr_cap[3*i+1] = pad_out_o[PAD_ORDER[i]];
      bsr_cap[3*i+2] = pad_oe_o[PAD_ORDER[i]];
    end
    bsr_cap[BSR_W-1] = ext_rst_b_i;
  end
  assign acc_cap = dbg_rdata_i;

  // ------------------------------------------------------------------
  // one fill of the next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rs = {s_q.rs[1:0], 1'b1};
    s_d.tck_s = {s_q.tck_s[1:0], tck_i};
    s_d.tms_s = {s_q.tms_s[1:0], tms_i};
    s_d.tdi_s = {s_q.tdi_s[1:0], tdi_i};
    s_d.trst_s = {s_q.trst_s[1:0], trst_b_i};
    s_d.tck_lvl = tck_lvl_new;
    s_d.abort = 1'b0;
    s_d.fifo_v = 1'b0;
    if (trst_v) begin
      s_d.st = S_TLR;
      s_d.ir = INS_IDCODE;
      s_d.oe = 1'b0;
    end else if (tck_rise) begin
      s_d.st = nx;
      if (s_q.st == S_TLR) begin
        s_d.ir = INS_IDCODE;
      end
      case (s_q.st)
        S_CAPIR: s_d.ir_sh = IR_CAPTURE;
        S_SHIR: s_d.ir_sh = {tdi_v, s_q.ir_sh[IR_W-1:1]};
        S_UPIR: s_d.ir = s_q.ir_sh;
        S_CAPDR: begin
          if (is_bsr) begin
            s_d.bsr = bsr_cap;
          end else if (is_acc) begin
            s_d.dr = acc_cap;
          end else if (is_id) begin
            s_d.dr = {3'h0, ID_VALUE};
          end else begin
            s_d.dr = '0;
          end
        end
        S_SHDR: begin
          if (is_bsr) begin
            s_d.bsr = {tdi_v, s_q.bsr[BSR_W-1:1]};
          end else if (is_acc) begin
            s_d.dr = {tdi_v, s_q.dr[ACC_W-1:1]};
          end else if (is_id) begin
            s_d.dr[ID_W-1:0] = {tdi_v, s_q.dr[ID_W-1:1]};
          end else begin
            s_d.dr[0] = tdi_v;
          end
        end
        S_UPDR: begin
          if (is_bsr) begin
            s_d.bsr_hold = s_q.bsr;
          end else if (is_acc) begin
            s_d.fifo_v = 1'b1;
            s_d.fifo_w = {s_q.ir[1:0], s_q.dr};
            s_d.abort = (s_q.ir == INS_ABORT) && s_q.dr[3];
          end
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      // tdo moves on the falling edge, driven only while shifting
      s_d.oe = (s_q.st == S_SHDR) || (s_q.st == S_SHIR);
      if (s_q.st == S_SHIR) begin
        s_d.tdo = s_q.ir_sh[0];
      end else if (is_bsr) begin
        s_d.tdo = s_q.bsr[0];
      end else begin
        s_d.tdo = s_q.dr[0];
      end
    end
  end

  // ------------------------------------------------------------------
  // registers; only power-on reset clears them
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      // tck idles high; matching it here avoids a false rise after reset
      s_q.tck_s <= 3'h7;
      s_q.tck_lvl <= 1'b1;
      s_q.trst_s <= 3'h7;
      s_q.st <= S_TLR;
      s_q.ir <= INS_IDCODE;
      s_q.ir_sh <= IR_CAPTURE;
    end else if (!rst_n) begin
      s_q.rs <= s_d.rs;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // pad muxing from held boundary values
  // ------------------------------------------------------------------
  always_comb begin
    pad_out_o = core_out_i;
    pad_oe_o = core_oe_i;
    core_in_o = pad_in_i;
    for (int i = 0; i < NPAD; i++) begin
      if (s_q.ir == INS_EXTEST) begin
        pad_out_o[PAD_ORDER[i]] = s_q.bsr_hold[3*i+1];
        pad_oe_o[PAD_ORDER[i]] = s_q.bsr_hold[3*i+2];
      end
      if (s_q.ir == INS_INTEST) begin
        core_in_o[PAD_ORDER[i]] = s_q.bsr_hold[3*i];
      end
    end
  end

  // updates beyond fifo room are dropped; debug unit must keep up
  jtp_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(mclk_i),
    .rst_b_i(rst_n),
    .in_valid_i(s_q.fifo_v),
    .in_ready_o(in_ready),
    .in_data_i(s_q.fifo_w),
    .out_valid_o(dbg_valid_o),
    .out_ready_i(dbg_ready_i),
    .out_data_o(fifo_rd)
  );

  assign dbg_kind_o = fifo_rd[FIFO_W-1:ACC_W];
  assign dbg_data_o = fifo_rd[ACC_W-1:0];
  assign tdo_o = s_q.tdo;
  assign tdo_oe_o = s_q.oe;
  assign instr_o = s_q.ir;
  assign abort_o = s_q.abort;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_tlr_id;
    @(posedge mclk_i) disable iff (!rst_n)
      (tck_rise && s_q.st == S_TLR && !trst_v) |=> s_q.ir == INS_IDCODE;
  endproperty
  a_tlr_id: assert property (p_tlr_id) else $error("no idcode in tlr");

  property p_ir_upd;
    @(posedge mclk_i) disable iff (!rst_n)
      (!(tck_rise && (s_q.st == S_UPIR || s_q.st == S_TLR)) && !trst_v)
        |=> $stable(s_q.ir);
  endproperty
  a_ir_upd: assert property (p_ir_upd) else $error("ir moved early");

  property p_byp_cap;
    @(posedge mclk_i) disable iff (!rst_n)
      (tck_rise && !trst_v && s_q.st == S_CAPDR && s_q.ir == INS_BYPASS)
        |=> s_q.dr[0] == 1'b0;
  endproperty
  a_byp_cap: assert property (p_byp_cap) else $error("bypass lsb");

  property p_id_cap;
    @(posedge mclk_i) disable iff (!rst_n)
      (tck_rise && !trst_v && s_q.st == S_CAPDR && is_id)
        |=> s_q.dr[31:0] == ID_VALUE && s_q.dr[0];
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("id capture");

  property p_extest;
    @(posedge mclk_i) disable iff (!rst_n)
      s_q.ir == INS_EXTEST |-> pad_out_o[PAD_ORDER[0]] == s_q.bsr_hold[1];
  endproperty
  a_extest: assert property (p_extest) else $error("extest pad");

  property p_intest;
    @(posedge mclk_i) disable iff (!rst_n)
      s_q.ir == INS_INTEST |-> core_in_o[PAD_ORDER[0]] == s_q.bsr_hold[0];
  endproperty
  a_intest: assert property (p_intest) else $error("intest core");

  property p_bsr_upd;
    @(posedge mclk_i) disable iff (!rst_n)
      (tck_rise && !trst_v && s_q.st == S_UPDR && is_bsr)
        |=> s_q.bsr_hold == $past(s_q.bsr);
  endproperty
  a_bsr_upd: assert property (p_bsr_upd) else $error("bsr hold");

  sequence s_acc_upd;
    tck_rise && !trst_v && s_q.st == S_UPDR && is_acc;
  endsequence
  property p_acc_fifo;
    @(posedge mclk_i) disable iff (!rst_n)
      s_acc_upd |=> s_q.fifo_v ##1 !s_q.fifo_v;
  endproperty
  a_acc_fifo: assert property (p_acc_fifo) else $error("acc push");

  property p_trst;
    @(posedge mclk_i) disable iff (!rst_n)
      trst_v |=> s_q.st == S_TLR && !s_q.oe;
  endproperty
  a_trst: assert property (p_trst) else $error("trst");

endmodule : jtp_tap

// file: verif/jtp_tester.sv
/*
  tester model for the scan port: drives tck, tms and tdi, reads tdo.
  assumes the bench clock paces it; tck runs only inside its tasks.
*/
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// tester: one link cycle is 8 bench clocks, 200 ns
// ----------------------------------------------------------------------
module jtp_tester (
  input wire logic mclk_i, // bench clock, paces the link
  input wire logic tdo_i,  // serial data from the port
  output logic tck_o,      // link clock, still between frames
  output logic tms_o,      // mode select
  output logic tdi_o       // serial data to the port
);
  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // fall, 4 clocks low, rise, 4 clocks high; tdo read before the
  // next fall, where it has long settled and still stands
  task automatic step(input logic m, input logic d, output logic o);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    o = tdo_i;
  endtask : step

  // tms-only step; tdi flips so a stale level is never mistaken
  task automatic move(input logic m);
    logic o;
    step(m, ~tdi_o, o);
  endtask : move

  // five ones reach test-logic-reset from anywhere, then idle
  task automatic to_idle();
    repeat (5) move(1'b1);
    move(1'b0);
  endtask : to_idle

  // from a select state: capture, shift n bits lsb first, stop in exit1
  task automatic scan(input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    dout = '0;
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask : scan

  // exit1 to update, then back to idle
  task automatic leave();
    move(1'b1);
    move(1'b0);
  endtask : leave
endmodule : jtp_tester

// file: verif/jtp_tap_test.sv
/*
  self-checking bench for jtp_tap: a table of instruction and data
  scans, then pad control, fifo overflow and the three resets.
  assumes jtp_tester as the far side and default pad order.
*/
`timescale 1ns/1ps

module jtp_tap_test;
  import jtp_pkg::*;

  // ----------------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------------
  typedef struct {logic [3:0] code; int len; logic [63:0] cap;} jtp_row_t;
  localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdf7;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic trst_b = 1'b1;
  logic ext_rst_b = 1'b1;
  logic dbg_ready = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, dbg_valid, abort;
  logic [NPAD-1:0] pad_in = 8'hc5;
  logic [NPAD-1:0] core_out = 8'h3a;
  logic [NPAD-1:0] core_oe = 8'h96;
  logic [NPAD-1:0] pad_out, pad_oe, core_in;
  logic [3:0] instr;
  logic [1:0] dbg_kind;
  logic [ACC_W-1:0] dbg_data;
  logic [ACC_W-1:0] dbg_rdata = 35'h2_9b31_c6e5;
  jtp_row_t rows [8];
  int n_errors = 0;
  int samples_checked = 0;
  int n_abort = 0;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  jtp_tap jtp_tap_inst (.mclk_i(mclk), .rst_b_i(rst_b), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_b_i(trst_b), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pad_in_i(pad_in), .core_out_i(core_out),
    .core_oe_i(core_oe), .ext_rst_b_i(ext_rst_b), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .core_in_o(core_in), .instr_o(instr),
    .dbg_valid_o(dbg_valid), .dbg_ready_i(dbg_ready),
    .dbg_kind_o(dbg_kind), .dbg_data_o(dbg_data),
    .dbg_rdata_i(dbg_rdata), .abort_o(abort));

  jtp_tester jtp_tester_inst (.mclk_i(mclk), .tdo_i(tdo), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  // abort is a one-clock pulse, so count it on every edge
  always @(posedge mclk) begin
    if (abort === 1'b1) n_abort++;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // old instruction must hold through the shift, new one after update
  task automatic load_ir(input logic [3:0] code);
    logic [63:0] cap;
    logic [3:0] old;
    old = instr;
    jtp_tester_inst.move(1'b1);
    jtp_tester_inst.move(1'b1);
    jtp_tester_inst.scan(IR_W, {60'h0, code}, cap);
    check(cap[3:0], IR_CAPTURE);
    check(instr, old);
    jtp_tester_inst.leave();
    // the update lands on the edge at which leave returns
    @(posedge mclk);
    check(instr, code);
  endtask : load_ir

  task automatic scan_dr(input int n, output logic [63:0] dout);
    jtp_tester_inst.move(1'b1);
    jtp_tester_inst.scan(n, PAT, dout);
    jtp_tester_inst.leave();
  endtask : scan_dr

  // wait for a queued word, compare it, then pop it
  task automatic take(input logic [1:0] kind);
    int w;
    w = 0;
    @(posedge mclk);
    while (dbg_valid !== 1'b1 && w < 100) begin
      @(posedge mclk);
      w++;
    end
    check(dbg_valid, 1'b1);
    check(dbg_kind, kind);
    check(dbg_data, PAT[ACC_W:1]);
    dbg_ready <= 1'b1;
    @(posedge mclk);
    dbg_ready <= 1'b0;
  endtask : take

  // capture image: slot i is input, output, enable; reset pin last
  function automatic logic [63:0] bsr_exp();
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < NPAD; i++) begin
      v[3*i] = pad_in[i];
      v[3*i+1] = core_out[i];
      v[3*i+2] = core_oe[i];
    end
    v[3*NPAD] = ext_rst_b;
    return v;
  endfunction : bsr_exp

  // ----------------------------------------------------------------------
  // watchdog: the sequence needs about 160 us
  // ----------------------------------------------------------------------
  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [63:0] got;
    logic [63:0] exp;
    logic [NPAD-1:0] eo, ee, ei;
    int n_got;
    n_got = 0;
    rows = '{'{INS_IDCODE, ID_W, 64'(ID_VALUE)}, '{INS_BYPASS, 1, '0},
      '{4'h5, 1, '0}, '{4'hc, 1, '0}, '{INS_ABORT, ACC_W, 64'(dbg_rdata)},
      '{INS_DP_ACCESS, ACC_W, 64'(dbg_rdata)},
      '{INS_AP_ACCESS, ACC_W, 64'(dbg_rdata)},
      '{INS_SAMPLE, BSR_W, bsr_exp()}};
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    check(instr, INS_IDCODE);
    check(tdo_oe, 1'b0);
    jtp_tester_inst.to_idle();
    // one extra bit shows each chain's length and captured value
    foreach (rows[r]) begin
      load_ir(rows[r].code);
      scan_dr(rows[r].len + 1, got);
      exp = rows[r].cap;
      exp[rows[r].len] = PAT[0];
      check(got, exp);
    end
    check(n_abort, 1);
    take(2'h0);
    take(2'h2);
    take(2'h3);
    // held boundary image is the pattern moved down by one bit
    for (int i = 0; i < NPAD; i++) begin
      ei[i] = PAT[3*i+1];
      eo[i] = PAT[3*i+2];
      ee[i] = PAT[3*i+3];
    end
    load_ir(INS_EXTEST);
    check(pad_out, eo);
    check(pad_oe, ee);
    check(core_in, pad_in);
    load_ir(INS_INTEST);
    check(core_in, ei);
    check(pad_out, core_out);
    ext_rst_b <= 1'b0;
    repeat (20) @(posedge mclk);
    check(instr, INS_INTEST);
    check(core_in, ei);
    ext_rst_b <= 1'b1;
    // fill past the fifo depth while the debug side stalls
    load_ir(INS_DP_ACCESS);
    repeat (FIFO_DEPTH + 1) scan_dr(ACC_W + 1, got);
    dbg_ready <= 1'b1;
    repeat (2 * FIFO_DEPTH) begin
      @(posedge mclk);
      if (dbg_valid === 1'b1) n_got++;
    end
    dbg_ready <= 1'b0;
    check(n_got, FIFO_DEPTH);
    // test-logic-reset by tms, by trst and by power-on reset
    load_ir(INS_BYPASS);
    jtp_tester_inst.to_idle();
    check(instr, INS_IDCODE);
    load_ir(INS_BYPASS);
    trst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    trst_b <= 1'b1;
    repeat (10) @(posedge mclk);
    check(instr, INS_IDCODE);
    jtp_tester_inst.move(1'b0);
    load_ir(INS_BYPASS);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    check(instr, INS_IDCODE);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    jtp_tester_inst.move(1'b0);
    scan_dr(ID_W, got);
    check(got, 64'(ID_VALUE));
    close_out();
  end
endmodule : jtp_tap_test
